// ===== hdl/biv_pkg.sv
// How it works
// - Reject image unless header validation word equals the fixed signature.
// - Header length field counts 32-bit words from offset zero through CRC.
// - Sum header bytes 0x40 through 0x49, compare with stored checksum.
// - CRC covers base 0xFFFF0000 to base+4*length-5; last word holds CRC.
// - CRC uses the standard 32-bit polynomial with the listed terms.
// - CRC starts all ones, final XOR all ones, no bit reflection.
// - Reject images larger than 60 KB; top 4 KB is boot workspace.
// - Image valid only after header checks and CRC check both pass.
// - After validation, control passes to the image entry-point address.
// - Handoff writes version word zero at shared offset 0x0008.
// - Handoff writes saved reset-cause value at shared offset 0x0038.
// - Shared block in top 4 KB; pointer and length passed to image.
// - Warm reset reuses last image index only if boot select unchanged.
package biv_pkg;

    // ------------------------------------------------------------
    // image layout
    // ------------------------------------------------------------
    localparam logic [31:0] IMG_BASE = 32'hFFFF_0000;
    localparam logic [31:0] RAM_BYTES = 32'h0001_0000;
    localparam logic [31:0] WORKSPACE_BYTES = 32'h0000_1000;
    localparam logic [31:0] SHARED_BASE = IMG_BASE + RAM_BYTES
                                          - WORKSPACE_BYTES;
    // arbitrary signature value for this build
    localparam logic [31:0] SIGNATURE = 32'h5AA5_C33C;
    localparam logic [13:0] IDX_SIG = 14'h0010;   // word at 0x40
    localparam logic [13:0] IDX_LEN = 14'h0011;   // word at 0x44
    localparam logic [13:0] IDX_CSUM = 14'h0012;  // word at 0x48
    localparam logic [13:0] IDX_HDR_END = 14'h0013;
    localparam int LEN_LSB = 16;                  // length at 0x46
    localparam int CSUM_LSB = 16;                 // checksum at 0x4A
    localparam int CSUM_W = 16;
    localparam logic [31:0] CSUM_TAIL_MASK = 32'h0000_FFFF;
    localparam logic [31:0] ENTRY_OFS = 32'h0000_0050;
    localparam logic [15:0] MIN_LEN = 16'h0014;
    localparam logic [15:0] MAX_LEN = 16'h3C00;   // 60 KB in words

    // ------------------------------------------------------------
    // crc and handoff
    // ------------------------------------------------------------
    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_XOROUT = 32'hFFFF_FFFF;
    localparam logic [31:0] SHM_VERSION_OFS = 32'h0000_0008;
    localparam logic [31:0] SHM_CAUSE_OFS = 32'h0000_0038;
    localparam logic [31:0] SHM_VERSION = 32'h0000_0000;
    localparam int FIFO_DEPTH = 4;
    localparam int WORD_W = 32;

    typedef enum {
        BIV_IDLE, BIV_RUN, BIV_WR_VER, BIV_WR_CAUSE, BIV_DONE, BIV_FAIL
    } biv_state_t;

    typedef struct packed {
        logic sig;
        logic size;
        logic csum;
        logic crc;
    } biv_fail_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } biv_mem_cmd_t;

endpackage : biv_pkg

// ===== hdl/biv_fifo.sv
`timescale 1ns/1ps
module biv_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    assign inReady = (count != AW'(0) + (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr];

    // storage
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    // pointers and fill level
    always_ff @(posedge ref_clk) begin
        if (!rst_n || flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : biv_fifo

// ===== hdl/biv_validator.sv
`timescale 1ns/1ps
module biv_validator (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic warmStart,
    input wire logic [2:0] boot_select_pins,
    input wire logic [1:0] reqIndex,
    input wire logic [31:0] resetCause,
    output biv_pkg::biv_mem_cmd_t memCmd,
    input wire logic [31:0] memRdata,
    input wire logic memRdValid,
    output logic busy,
    output logic imageValid,
    output biv_pkg::biv_fail_t failFlags,
    output logic jumpGo,
    output logic [31:0] entryAddr,
    output logic [31:0] shared_block_pointer,
    output logic [31:0] shared_block_length,
    output logic [1:0] selIndex
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // advance a non-reflected crc by one byte, msb first
    function automatic logic [31:0] crcByte(input logic [31:0] crc,
                                            input logic [7:0] b);
        logic [31:0] c;
        logic fb;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            fb = c[31] ^ b[i];
            c = {c[30:0], 1'b0} ^ (fb ? biv_pkg::CRC_POLY : 32'h0000_0000);
        end
        return c;
    endfunction : crcByte

    // unsigned sum of the four bytes of a word
    function automatic logic [15:0] byteSum(input logic [31:0] w);
        return 16'(w[7:0]) + 16'(w[15:8]) + 16'(w[23:16]) + 16'(w[31:24]);
    endfunction : byteSum

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    biv_pkg::biv_state_t state;
    logic [2:0] bselMeta;
    logic [2:0] bselSync;
    logic [2:0] prevBootSel;
    logic [1:0] lastIndex;
    logic haveLast;
    logic [31:0] causeHold;
    logic outstanding;
    logic [13:0] fetchIdx;
    logic [13:0] wordIdx;
    logic [15:0] lenWords;
    logic lenKnown;
    logic [15:0] csumAcc;
    logic [31:0] crcAcc;
    logic [31:0] wordBuf;
    logic haveWord;
    logic [1:0] bytePos;
    logic fifoFlush;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [31:0] fifoOutData;
    logic [13:0] fetchLimit;
    logic issueRead;
    logic takeWord;
    logic isLast;
    logic [15:0] next_csum;

    // ------------------------------------------------------------
    // word buffer between ram and checker
    // ------------------------------------------------------------
    biv_fifo #(
        .WIDTH(biv_pkg::WORD_W),
        .DEPTH(biv_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .flush(fifoFlush),
        .inValid(memRdValid && outstanding && state == biv_pkg::BIV_RUN),
        .inReady(fifoInReady),
        .inData(memRdata),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    assign fifoFlush = start;

    // ------------------------------------------------------------
    // fetch and take conditions
    // ------------------------------------------------------------

    // fetch only words up to the header end until the length is known
    // length in words
    assign fetchLimit = lenKnown ? lenWords[13:0] : biv_pkg::IDX_HDR_END;
    // one read in flight; fifo room is reserved when it is issued
    assign issueRead = (state == biv_pkg::BIV_RUN) && !outstanding
                       && fifoInReady && (fetchIdx < fetchLimit);
    // checker stalls four cycles per word while the crc runs byte-wise
    assign fifoOutReady = (state == biv_pkg::BIV_RUN) && !haveWord;
    assign takeWord = fifoOutReady && fifoOutValid;
    assign isLast = lenKnown && (wordIdx == lenWords[13:0] - 14'h0001);
    assign next_csum = csumAcc + byteSum(fifoOutData);

    // ------------------------------------------------------------
    // boot select synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bselMeta <= 3'h0;
            bselSync <= 3'h0;
        end else begin
            bselMeta <= boot_select_pins;
            bselSync <= bselMeta;
        end
    end

    // ------------------------------------------------------------
    // image selection and warm-boot memory
    // ------------------------------------------------------------

    // only a cold reset clears the remembered image
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            selIndex <= 2'h0;
            lastIndex <= 2'h0;
            prevBootSel <= 3'h0;
            haveLast <= 1'b0;
        end else if (start) begin
            if (warmStart && haveLast && bselSync == prevBootSel) begin
                selIndex <= lastIndex;
            end else begin
                selIndex <= reqIndex;
            end
        end else if (state == biv_pkg::BIV_WR_CAUSE) begin
            lastIndex <= selIndex;
            prevBootSel <= bselSync;
            haveLast <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read issue and outstanding tracking
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            outstanding <= 1'b0;
            fetchIdx <= 14'h0000;
        end else begin
            if (start) begin
                fetchIdx <= 14'h0000;
            end else if (issueRead) begin
                fetchIdx <= fetchIdx + 14'h0001;
            end
            if (issueRead) begin
                outstanding <= 1'b1;
            end else if (memRdValid) begin
                outstanding <= 1'b0;
            end
        end
    end

    // memory command: reads while checking, two writes at handoff
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            memCmd <= '0;
        end else begin
            memCmd <= '0;
            if (issueRead) begin
                memCmd.valid <= 1'b1;
                memCmd.addr <= biv_pkg::IMG_BASE + {16'h0000, fetchIdx, 2'b00};
            end else if (state == biv_pkg::BIV_WR_VER) begin
                memCmd.valid <= 1'b1;
                memCmd.we <= 1'b1;
                memCmd.addr <= biv_pkg::SHARED_BASE + biv_pkg::SHM_VERSION_OFS;
                memCmd.wdata <= biv_pkg::SHM_VERSION;
            end else if (state == biv_pkg::BIV_WR_CAUSE) begin
                memCmd.valid <= 1'b1;
                memCmd.we <= 1'b1;
                memCmd.addr <= biv_pkg::SHARED_BASE + biv_pkg::SHM_CAUSE_OFS;
                memCmd.wdata <= causeHold;
            end
        end
    end

    // ------------------------------------------------------------
    // byte-serial crc engine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            crcAcc <= biv_pkg::CRC_INIT;
            wordBuf <= 32'h0000_0000;
            haveWord <= 1'b0;
            bytePos <= 2'h0;
        end else if (start) begin
            crcAcc <= biv_pkg::CRC_INIT;
            haveWord <= 1'b0;
            bytePos <= 2'h0;
        end else if (takeWord && !isLast) begin
            wordBuf <= fifoOutData;
            haveWord <= 1'b1;
            bytePos <= 2'h0;
        end else if (haveWord) begin
            // polynomial step, lowest address byte first
            crcAcc <= crcByte(crcAcc, wordBuf[8*bytePos +: 8]);
            bytePos <= bytePos + 2'h1;
            if (bytePos == 2'h3) begin
                haveWord <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // header field capture
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wordIdx <= 14'h0000;
            lenWords <= 16'h0000;
            lenKnown <= 1'b0;
            csumAcc <= 16'h0000;
        end else if (start) begin
            wordIdx <= 14'h0000;
            lenKnown <= 1'b0;
            csumAcc <= 16'h0000;
        end else if (takeWord) begin
            wordIdx <= wordIdx + 14'h0001;
            if (wordIdx == biv_pkg::IDX_SIG || wordIdx == biv_pkg::IDX_LEN) begin
                csumAcc <= next_csum;
            end
            if (wordIdx == biv_pkg::IDX_LEN) begin
                lenWords <= fifoOutData[biv_pkg::LEN_LSB +: 16];
                lenKnown <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // check sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= biv_pkg::BIV_IDLE;
            failFlags <= '0;
            causeHold <= 32'h0000_0000;
        end else if (start) begin
            state <= biv_pkg::BIV_RUN;
            failFlags <= '0;
            causeHold <= resetCause;
        end else begin
            case (state)
                biv_pkg::BIV_RUN: begin
                    if (takeWord) begin
                        if (wordIdx == biv_pkg::IDX_SIG
                            && fifoOutData != biv_pkg::SIGNATURE) begin
                            failFlags.sig <= 1'b1;
                            state <= biv_pkg::BIV_FAIL;
                        end
                        if (wordIdx == biv_pkg::IDX_LEN
                            && (fifoOutData[biv_pkg::LEN_LSB +: 16]
                                > biv_pkg::MAX_LEN
                                || fifoOutData[biv_pkg::LEN_LSB +: 16]
                                < biv_pkg::MIN_LEN)) begin
                            failFlags.size <= 1'b1;
                            state <= biv_pkg::BIV_FAIL;
                        end
                        if (wordIdx == biv_pkg::IDX_CSUM
                            && csumAcc
                               + byteSum(fifoOutData & biv_pkg::CSUM_TAIL_MASK)
                               != fifoOutData[biv_pkg::CSUM_LSB +:
                                              biv_pkg::CSUM_W]) begin
                            failFlags.csum <= 1'b1;
                            state <= biv_pkg::BIV_FAIL;
                        end
                        if (isLast) begin
                            if ((crcAcc ^ biv_pkg::CRC_XOROUT)
                                != fifoOutData) begin
                                failFlags.crc <= 1'b1;
                                state <= biv_pkg::BIV_FAIL;
                            end else begin
                                state <= biv_pkg::BIV_WR_VER;
                            end
                        end
                    end
                end
                biv_pkg::BIV_WR_VER: begin
                    state <= biv_pkg::BIV_WR_CAUSE;
                end
                biv_pkg::BIV_WR_CAUSE: begin
                    state <= biv_pkg::BIV_DONE;
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // result outputs and handoff
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            imageValid <= 1'b0;
            jumpGo <= 1'b0;
            entryAddr <= 32'h0000_0000;
        end else begin
            busy <= start || (state == biv_pkg::BIV_RUN
                              || state == biv_pkg::BIV_WR_VER)
                          && !(state == biv_pkg::BIV_RUN && takeWord && isLast
                               && (crcAcc ^ biv_pkg::CRC_XOROUT)
                                  != fifoOutData);
            jumpGo <= 1'b0;
            if (start) begin
                imageValid <= 1'b0;
            end else if (state == biv_pkg::BIV_WR_CAUSE) begin
                imageValid <= 1'b1;
                jumpGo <= 1'b1;
                entryAddr <= biv_pkg::IMG_BASE + biv_pkg::ENTRY_OFS;
            end
        end
    end

    // shared block location passed to the image
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shared_block_pointer <= 32'h0000_0000;
            shared_block_length <= 32'h0000_0000;
        end else begin
            shared_block_pointer <= biv_pkg::SHARED_BASE;
            shared_block_length <= biv_pkg::WORKSPACE_BYTES;
        end
    end

endmodule : biv_validator

// ===== verif/biv_validator_properties.sv
`timescale 1ns/1ps
module biv_validator_properties (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire biv_pkg::biv_mem_cmd_t memCmd,
    input wire logic imageValid,
    input wire biv_pkg::biv_fail_t failFlags,
    input wire logic jumpGo,
    input wire logic [31:0] entryAddr,
    input wire logic [31:0] shared_block_pointer,
    input wire logic [31:0] shared_block_length
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // output relations
    // ------------------------------------------------------------
    a_jump_with_valid: assert property (jumpGo |-> $rose(imageValid))
        else $error("jump without fresh valid");
    a_jump_one_pulse: assert property (jumpGo |=> !jumpGo)
        else $error("jump pulse too long");
    a_entry_addr: assert property (jumpGo |->
        entryAddr == biv_pkg::IMG_BASE + biv_pkg::ENTRY_OFS)
        else $error("wrong entry address");
    a_valid_no_fail: assert property (imageValid |-> failFlags == 4'h0)
        else $error("valid while failing");
    a_fail_onehot: assert property ($onehot0(failFlags))
        else $error("more than one fail flag");
    a_shared_ptr: assert property ($past(rst_n) |->
        shared_block_pointer == biv_pkg::SHARED_BASE &&
        shared_block_length == biv_pkg::WORKSPACE_BYTES)
        else $error("bad shared block pointer");
    // cause write, valid and jump all show in the cycle after the version
    a_handoff_order: assert property (memCmd.valid && memCmd.we &&
        memCmd.addr == biv_pkg::SHARED_BASE + biv_pkg::SHM_VERSION_OFS
        |-> (memCmd.wdata == biv_pkg::SHM_VERSION) ##1 (memCmd.valid &&
        memCmd.we && memCmd.addr == biv_pkg::SHARED_BASE +
        biv_pkg::SHM_CAUSE_OFS && imageValid && jumpGo))
        else $error("handoff order wrong");
    a_read_range: assert property (memCmd.valid && !memCmd.we |->
        memCmd.addr < biv_pkg::SHARED_BASE && memCmd.addr[1:0] == 2'h0)
        else $error("read outside image area");

    c_pass: cover property ($rose(imageValid));
    c_crc_fail: cover property ($rose(failFlags.crc));
    c_size_fail: cover property ($rose(failFlags.size));
endmodule : biv_validator_properties

// ===== verif/biv_ram_model.sv
`timescale 1ns/1ps
module biv_ram_model (
    input wire logic ref_clk,
    input wire logic [3:0] latency,
    input wire biv_pkg::biv_mem_cmd_t memCmd,
    output logic [31:0] memRdata,
    output logic memRdValid
);
    logic [31:0] img [256];
    logic [31:0] verWord;
    logic [31:0] causeWord;
    int wrCount = 0;
    logic pending = 1'b0;
    logic [3:0] waitCnt = 4'h0;
    logic [31:0] rdOfs = 32'h0000_0000;

    initial memRdata = 32'h0000_0000;
    initial memRdValid = 1'b0;

    // read answer after the set latency; idle data toggles every cycle
    always @(posedge ref_clk) begin
        memRdValid <= 1'b0;
        memRdata <= ~memRdata;
        if (pending && waitCnt == 4'h0) begin
            memRdValid <= 1'b1;
            memRdata <= img[rdOfs[9:2]];
            pending <= 1'b0;
        end else if (pending) begin
            waitCnt <= waitCnt - 4'h1;
        end
        if (memCmd.valid && !memCmd.we) begin
            pending <= 1'b1;
            waitCnt <= latency - 4'h1;
            rdOfs <= memCmd.addr - biv_pkg::IMG_BASE;
        end
    end

    always @(posedge ref_clk) begin
        if (memCmd.valid && memCmd.we) begin
            wrCount <= wrCount + 1;
            if (memCmd.addr == biv_pkg::SHARED_BASE + 32'h0000_0008) begin
                verWord <= memCmd.wdata;
            end
            if (memCmd.addr == biv_pkg::SHARED_BASE + 32'h0000_0038) begin
                causeWord <= memCmd.wdata;
            end
        end
    end
endmodule : biv_ram_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic warmStart = 1'b0;
    logic [2:0] bootSel = 3'h5;
    logic [1:0] reqIndex = 2'h0;
    logic [31:0] resetCause = 32'h0000_0000;
    logic [3:0] latency = 4'h1;
    biv_pkg::biv_mem_cmd_t memCmd;
    logic [31:0] memRdata;
    logic memRdValid;
    logic busy;
    logic imageValid;
    biv_pkg::biv_fail_t failFlags;
    logic jumpGo;
    logic [1:0] selIndex;
    int jumps = 0;
    int errors = 0;
    int check_count = 0;

    always #20 ref_clk = ~ref_clk;

    biv_validator u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
        .warmStart(warmStart), .boot_select_pins(bootSel),
        .reqIndex(reqIndex), .resetCause(resetCause), .memCmd(memCmd),
        .memRdata(memRdata), .memRdValid(memRdValid), .busy(busy),
        .imageValid(imageValid), .failFlags(failFlags), .jumpGo(jumpGo),
        .entryAddr(), .shared_block_pointer(), .shared_block_length(),
        .selIndex(selIndex));
    biv_ram_model u_mem (.ref_clk(ref_clk), .latency(latency),
        .memCmd(memCmd), .memRdata(memRdata), .memRdValid(memRdValid));

    // count jump pulses
    always @(posedge ref_clk) begin
        if (jumpGo === 1'b1) begin
            jumps <= jumps + 1;
        end
    end

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ b[k]) ? biv_pkg::CRC_POLY : 0);
        end
        return c;
    endfunction : crc_byte

    // fill the image; bad picks 1 signature, 3 checksum, 4 crc damage
    task automatic build(input logic [15:0] len, input int bad);
        logic [15:0] s;
        logic [31:0] c;
        s = 16'h0000;
        c = biv_pkg::CRC_INIT;
        for (int i = 0; i < 256; i++) begin
            u_mem.img[i] = 32'h1357_9BDF ^ (32'(i) * 32'h0001_0203);
        end
        // the entry-point word at 0x50 carries a fixed marker value
        u_mem.img[20] = 32'h4953_5756;
        u_mem.img[16] = biv_pkg::SIGNATURE
                        ^ ((bad == 1) ? 32'h0000_0100 : 32'h0000_0000);
        u_mem.img[17] = {len, 16'h00A5};
        u_mem.img[18] = 32'h0000_3C5A;
        for (int i = 64; i < 74; i++) begin
            s = s + 16'(u_mem.img[i / 4][8 * (i % 4) +: 8]);
        end
        u_mem.img[18][31:16] = s + 16'(bad == 3);
        for (int w = 0; w + 1 < int'(len) && w < 255; w++) begin
            for (int b = 0; b < 4; b++) begin
                c = crc_byte(c, u_mem.img[w][8 * b +: 8]);
            end
        end
        if (len <= 16'h0100) begin
            u_mem.img[len - 1] = c ^ biv_pkg::CRC_XOROUT ^ 32'(bad == 4);
        end
    endtask : build

    // one run from start to end of busy, then judge the outcome
    task automatic run(input logic [3:0] lat, input logic warm,
        input logic [1:0] idx, input logic [3:0] expFail,
        input logic [1:0] expSel);
        int n;
        int wr0;
        n = 0;
        wr0 = u_mem.wrCount;
        jumps = 0;
        u_mem.verWord = 32'hFFFF_FFFF;
        u_mem.causeWord = 32'hFFFF_FFFF;
        @(posedge ref_clk);
        latency <= lat;
        warmStart <= warm;
        reqIndex <= idx;
        resetCause <= 32'h00C0_0000 | 32'(lat);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        chk("busy", 32'h1, 32'(busy));
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (busy !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            errors++;
            close_out();
        end
        repeat (4) @(posedge ref_clk);
        #1;
        chk("fail", 32'(expFail), 32'(failFlags));
        chk("valid", 32'(expFail == 0), 32'(imageValid));
        chk("sel", 32'(expSel), 32'(selIndex));
        chk("jumps", 32'(expFail == 0), 32'(jumps));
        chk("writes", 32'(expFail == 0) * 2, 32'(u_mem.wrCount - wr0));
        if (expFail == 0) begin
            chk("version", biv_pkg::SHM_VERSION, u_mem.verWord);
            chk("cause", resetCause, u_mem.causeWord);
        end
    endtask : run

    // each damaged header or image raises its own flag
    task automatic t_fail_table;
        logic [15:0] lens [5] = '{16'h0018, 16'h3C01, 16'h0013, 16'h0018,
                                  16'h0018};
        int bads [5] = '{1, 0, 0, 3, 4};
        logic [3:0] flags [5] = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h1};
        for (int k = 0; k < 5; k++) begin
            build(lens[k], bads[k]);
            run(4'h2, 1'b0, 2'h0, flags[k], 2'h0);
        end
    endtask : t_fail_table

    // shortest image with fast memory, longer one with slow memory
    task automatic t_pass;
        build(16'h0014, 0);
        run(4'h1, 1'b0, 2'h1, 4'h0, 2'h1);
        build(16'h0040, 0);
        run(4'h6, 1'b0, 2'h1, 4'h0, 2'h1);
    endtask : t_pass

    // warm runs reuse the last index only with unchanged boot select
    task automatic t_warm;
        run(4'h1, 1'b1, 2'h2, 4'h0, 2'h1);
        @(posedge ref_clk);
        bootSel <= 3'h2;
        repeat (3) @(posedge ref_clk);
        run(4'h1, 1'b1, 2'h2, 4'h0, 2'h2);
        run(4'h1, 1'b1, 2'h3, 4'h0, 2'h2);
        run(4'h1, 1'b0, 2'h3, 4'h0, 2'h3);
    endtask : t_warm

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_fail_table();
        t_pass();
        t_warm();
        close_out();
    end
endmodule : testbench

bind biv_validator biv_validator_properties u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .memCmd(memCmd),
    .imageValid(imageValid), .failFlags(failFlags), .jumpGo(jumpGo),
    .entryAddr(entryAddr), .shared_block_pointer(shared_block_pointer),
    .shared_block_length(shared_block_length));
